// file: verilog/spi_slave_byte_interface.v
// four-line spi slave front end with byte classification
`timescale 1ns/1ns
`default_nettype none
`include "spi_slave_defs.vh"
module spi_slave_byte_interface (
   // clock and reset
   input  wire                   clk_sys,
   input  wire                   reset,
   // spi pins
   input  wire                   chipEnable_n,
   input  wire                   serialClock,
   input  wire                   serial_data_in,
   output reg                    serial_data_out,
   output reg                    serialDataOutEn,
   // decoded outputs
   output reg  [`BYTE_WIDTH-1:0] cmdData,
   output reg                    cmdStrobe,
   output reg  [`PTR_WIDTH-1:0]  dataPtr,
   output reg                    overflow
);
   localparam ST_SUB  = 4'b0001;
   localparam ST_CTRL = 4'b0010;
   localparam ST_DATA = 4'b0100;
   localparam ST_SKIP = 4'b1000;

   // pin synchronisers
   reg [1:0] ceSync_reg;
   reg [1:0] sclSync_reg;
   reg [1:0] sdiSync_reg;
   reg       sclLast_reg;
   wire      ceActive;
   wire      sclRise;
   wire      sclFall;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ceSync_reg  <= 2'h3;
         sclSync_reg <= 2'h0;
         sdiSync_reg <= 2'h0;
         sclLast_reg <= 1'b0;
      end else begin
         ceSync_reg  <= {ceSync_reg[0], chipEnable_n};
         sclSync_reg <= {sclSync_reg[0], serialClock};
         sdiSync_reg <= {sdiSync_reg[0], serial_data_in};
         sclLast_reg <= sclSync_reg[1];
      end
   end

   assign ceActive = !ceSync_reg[1];
   assign sclRise  = ceActive && sclSync_reg[1] && !sclLast_reg;
   assign sclFall  = ceActive && !sclSync_reg[1] && sclLast_reg;

   // byte assembly
   reg [`BYTE_WIDTH-1:0]   shift_reg;
   reg [`BIT_CNT_WIDTH-1:0] bitCnt_reg;
   reg [3:0]               state_reg;
   reg [3:0]               state_next;
   reg                     readMode_reg;
   reg                     isCmd_reg;
   reg                     contCtrl_reg;
   reg                     pushValid;
   reg [`BYTE_WIDTH:0]     pushData;
   wire [`BYTE_WIDTH-1:0]  rxByte;
   wire                    byteDone;
   wire                    fifoReady;
   wire                    fifoValid;
   wire [`BYTE_WIDTH:0]    fifoData;
   wire                    sinkReady;
   wire [`BYTE_WIDTH-1:0]  sinkRead;
   wire [`BYTE_WIDTH-1:0]  sinkCmd;
   wire                    sinkStrobe;
   wire [`PTR_WIDTH-1:0]   sinkPtr;
   reg [`BYTE_WIDTH-1:0]   txShift_reg;

   assign rxByte   = {shift_reg[`BYTE_WIDTH-2:0], sdiSync_reg[1]};
   assign byteDone = sclRise && (bitCnt_reg == `BIT_CNT_LAST);

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         shift_reg  <= 8'h00;
         bitCnt_reg <= 3'h0;
      end else if (!ceActive) begin
         shift_reg  <= 8'h00;
         bitCnt_reg <= 3'h0;
      end else if (sclRise) begin
         shift_reg  <= rxByte;
         bitCnt_reg <= bitCnt_reg + 1'b1;
      end
   end

   // byte classification
   always @* begin
      state_next = state_reg;
      pushValid  = 1'b0;
      pushData   = {isCmd_reg, rxByte};
      if (byteDone) begin
         case (state_reg)
            ST_SUB: begin
               if (rxByte[`SUB_SEL_HI:`SUB_SEL_LO] == `SUB_SEL_MATCH) begin
                  state_next = ST_CTRL;
               end else begin
                  state_next = ST_SKIP;
               end
            end
            ST_CTRL: begin
               state_next = readMode_reg ? ST_SKIP : ST_DATA;
            end
            ST_DATA: begin
               pushValid  = 1'b1;
               state_next = contCtrl_reg ? ST_CTRL : ST_DATA;
            end
            ST_SKIP: begin
               state_next = ST_SKIP;
            end
            default: begin
               state_next = ST_SUB;
            end
         endcase
      end
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg    <= ST_SUB;
         readMode_reg <= 1'b0;
         isCmd_reg    <= 1'b0;
         contCtrl_reg <= 1'b0;
         overflow     <= 1'b0;
      end else if (!ceActive) begin
         state_reg    <= ST_SUB;
         readMode_reg <= 1'b0;
         contCtrl_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (byteDone && state_reg == ST_SUB) begin
            // a foreign select code must never turn the output on
            readMode_reg <= rxByte[`SUB_RW_BIT] &&
                            (rxByte[`SUB_SEL_HI:`SUB_SEL_LO] == `SUB_SEL_MATCH);
         end
         if (byteDone && state_reg == ST_CTRL) begin
            isCmd_reg    <= !rxByte[`CTRL_RS_BIT];
            contCtrl_reg <= rxByte[`CTRL_CONT_BIT];
         end
         if (pushValid && !fifoReady) begin
            overflow <= 1'b1;
         end
      end
   end

   sync_fifo #(
      .WIDTH (`BYTE_WIDTH + 1),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_ADDR_WIDTH)
   ) byteFifo (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .inData   (pushData),
      .inValid  (pushValid),
      .inReady  (fifoReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (sinkReady)
   );

   display_sink sink (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .inData    (fifoData),
      .inValid   (fifoValid),
      .inReady   (sinkReady),
      .readData  (sinkRead),
      .cmdData   (sinkCmd),
      .cmdStrobe (sinkStrobe),
      .dataPtr   (sinkPtr)
   );

   // readout path and output registers
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txShift_reg     <= 8'h00;
         serial_data_out <= 1'b0;
         serialDataOutEn <= 1'b0;
         cmdData         <= 8'h00;
         cmdStrobe       <= 1'b0;
         dataPtr         <= `PTR_RESET;
      end else begin
         cmdData   <= sinkCmd;
         cmdStrobe <= sinkStrobe;
         dataPtr   <= sinkPtr;
         if (!ceActive || !readMode_reg || state_reg == ST_SUB) begin
            serialDataOutEn <= 1'b0;
            serial_data_out <= 1'b0;
            txShift_reg     <= sinkRead;
         end else if (sclFall) begin
            serialDataOutEn <= 1'b1;
            serial_data_out <= txShift_reg[`BYTE_WIDTH-1];
            if (bitCnt_reg == 3'h0) begin
               serial_data_out <= sinkRead[`BYTE_WIDTH-1];
               txShift_reg     <= {sinkRead[`BYTE_WIDTH-2:0], 1'b0};
            end else begin
               txShift_reg <= {txShift_reg[`BYTE_WIDTH-2:0], 1'b0};
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/spi_slave_defs.vh
// constants for the spi slave byte interface
`ifndef SPI_SLAVE_DEFS_VH
`define SPI_SLAVE_DEFS_VH
`define BYTE_WIDTH        8
`define BIT_CNT_WIDTH     3
`define BIT_CNT_LAST      3'h7
`define SUB_RW_BIT        7
`define SUB_SEL_HI        6
`define SUB_SEL_LO        5
`define SUB_SEL_MATCH     2'h1
`define CTRL_CONT_BIT     7
`define CTRL_RS_BIT       6
`define FIFO_DEPTH        8
`define FIFO_ADDR_WIDTH   3
`define PTR_WIDTH         7
`define PTR_RESET         7'h00
`define RAM_DEPTH         128
`endif

// file: verilog/sync_fifo.v
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire             clk_sys,
   input  wire             reset,
   // fill side
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   // drain side
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wrPtr_reg;
   reg [AW:0]      rdPtr_reg;
   wire            doWrite;
   wire            doRead;

   assign inReady  = (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]) ||
                     (wrPtr_reg[AW] == rdPtr_reg[AW]);
   assign outValid = (wrPtr_reg != rdPtr_reg);
   assign outData  = mem[rdPtr_reg[AW-1:0]];
   assign doWrite  = inValid && inReady;
   assign doRead   = outValid && outReady;

   always @(posedge clk_sys) begin
      if (doWrite) begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wrPtr_reg <= {(AW+1){1'b0}};
         rdPtr_reg <= {(AW+1){1'b0}};
      end else begin
         if (doWrite) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (doRead) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/display_sink.v
// display ram and command sink fed from the byte fifo
`timescale 1ns/1ns
`default_nettype none
`include "spi_slave_defs.vh"
module display_sink (
   // clock and reset
   input  wire                     clk_sys,
   input  wire                     reset,
   // byte stream: bit 8 set marks command
   input  wire [`BYTE_WIDTH:0]     inData,
   input  wire                     inValid,
   output reg                      inReady,
   // readback of the byte at the pointer
   output reg  [`BYTE_WIDTH-1:0]   readData,
   // decoded commands
   output reg  [`BYTE_WIDTH-1:0]   cmdData,
   output reg                      cmdStrobe,
   output reg  [`PTR_WIDTH-1:0]    dataPtr
);
   reg [`BYTE_WIDTH-1:0] ram [0:`RAM_DEPTH-1];
   reg                   take;

   always @* begin
      take = inValid && inReady;
   end

   always @(posedge clk_sys) begin
      if (take && !inData[`BYTE_WIDTH]) begin
         ram[dataPtr] <= inData[`BYTE_WIDTH-1:0];
      end
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         inReady   <= 1'b0;
         cmdData   <= 8'h00;
         cmdStrobe <= 1'b0;
         dataPtr   <= `PTR_RESET;
         readData  <= 8'h00;
      end else begin
         // every other cycle ready, so the fifo can really back up
         inReady   <= !inReady;
         cmdStrobe <= 1'b0;
         readData  <= ram[dataPtr];
         if (take) begin
            if (inData[`BYTE_WIDTH]) begin
               cmdData   <= inData[`BYTE_WIDTH-1:0];
               cmdStrobe <= 1'b1;
            end else begin
               dataPtr <= dataPtr + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: test/spi_master_model.sv
// behavioural spi master driving the slave's pins
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
   // spi pins
   output logic chipEnable_n,
   output logic serialClock,
   output logic serial_data_in,
   input  wire logic serial_data_out
);
   logic [7:0] readByte;
   initial begin
      readByte = 8'h00;
      chipEnable_n = 1'b1;
      serialClock = 1'b0;
      serial_data_in = 1'b0;
   end
   // clock idles low, rises mid-bit
   task automatic open_frame();
      chipEnable_n = 1'b0;
      #63;
   endtask
   task automatic shift(input logic [7:0] b, input int nBits);
      for (int i = 7; i > 7 - nBits; i--) begin
         serial_data_in = b[i];
         #62 serialClock = 1'b1;
         readByte = {readByte[6:0], serial_data_out};
         #63 serialClock = 1'b0;
      end
   endtask
   // released line shows the inverse of the last bit
   task automatic close_frame();
      #63 chipEnable_n = 1'b1;
      serial_data_in = ~serial_data_in;
      #250;
   endtask
endmodule
`default_nettype wire

// file: test/spi_slave_chk.sv
// checker for the spi slave byte interface ports
`timescale 1ns/1ns
`default_nettype none
module spi_slave_chk (
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       chipEnable_n,
   input wire logic       serialClock,
   input wire logic       serial_data_out,
   input wire logic       serialDataOutEn,
   input wire logic [7:0] cmdData,
   input wire logic       cmdStrobe,
   input wire logic [6:0] dataPtr
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [5:0] ceHigh;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) ceHigh <= 6'h00;
      else if (!chipEnable_n) ceHigh <= 6'h00;
      else if (ceHigh != 6'h3F) ceHigh <= ceHigh + 6'h01;
   end
   property p_ce_off; chipEnable_n [*6] |-> !serialDataOutEn; endproperty
   a_ce_off: assert property (p_ce_off) else $error("output enabled while deselected");
   property p_out_zero; !serialDataOutEn |-> !serial_data_out; endproperty
   a_out_zero: assert property (p_out_zero) else $error("data out not idle");
   property p_strobe; cmdStrobe |=> !cmdStrobe; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe too long");
   property p_cmd_new; $changed(cmdData) |-> cmdStrobe; endproperty
   a_cmd_new: assert property (p_cmd_new) else $error("command without strobe");
   property p_ptr; $changed(dataPtr) |-> dataPtr == $past(dataPtr) + 7'h01; endproperty
   a_ptr: assert property (p_ptr) else $error("pointer step wrong");
   property p_kind; cmdStrobe |-> $stable(dataPtr); endproperty
   a_kind: assert property (p_kind) else $error("byte both kinds");
   property p_en_ce; $rose(serialDataOutEn) |-> !chipEnable_n; endproperty
   a_en_ce: assert property (p_en_ce) else $error("enable while deselected");
   property p_fall; serialDataOutEn && $changed(serial_data_out) |-> !serialClock; endproperty
   a_fall: assert property (p_fall) else $error("data out moved with clock high");
   property p_end; ceHigh >= 6'd40 |-> !cmdStrobe; endproperty
   a_end: assert property (p_end) else $error("activity after access end");
endmodule
bind spi_slave_byte_interface spi_slave_chk chk (.clk_sys(clk_sys), .reset(reset),
   .chipEnable_n(chipEnable_n), .serialClock(serialClock),
   .serial_data_out(serial_data_out), .serialDataOutEn(serialDataOutEn),
   .cmdData(cmdData), .cmdStrobe(cmdStrobe), .dataPtr(dataPtr));
`default_nettype wire

// file: test/spi_slave_byte_interface_bench.sv
// self-checking bench for the spi slave byte interface
`timescale 1ns/1ns
`default_nettype none
`define CHECK(w, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s expected %h seen %h", w, e, g); end end
module spi_slave_byte_interface_bench;
   logic       clk_sys, reset, chipEnable_n, serialClock, serial_data_in;
   logic       serial_data_out, serialDataOutEn, cmdStrobe, overflow;
   logic [7:0] cmdData, got;
   logic [7:0] ramModel [0:127];
   logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
   int         enCount = 0;
   int         k;
   logic [6:0] dataPtr, lastPtr, ptrExp;
   logic [7:0] cmdQ[$], bq[$];
   logic [6:0] ptrQ[$];
   int         bad_count = 0;
   int         n_compared = 0;
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   spi_master_model master (.chipEnable_n(chipEnable_n), .serialClock(serialClock),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));
   // counts cycles with the data output driven
   always @(negedge clk_sys) begin
      if (serialDataOutEn === 1'b1) enCount++;
   end
   spi_slave_byte_interface uut (.clk_sys(clk_sys), .reset(reset),
      .chipEnable_n(chipEnable_n), .serialClock(serialClock),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serialDataOutEn(serialDataOutEn), .cmdData(cmdData), .cmdStrobe(cmdStrobe),
      .dataPtr(dataPtr), .overflow(overflow));
   // result watcher
   always @(negedge clk_sys) begin
      if (reset) lastPtr = 7'h00;
      else begin
         if (cmdStrobe === 1'b1) begin
            got = (cmdQ.size() > 0) ? cmdQ.pop_front() : ~cmdData;
            `CHECK("cmdData", got, cmdData)
         end
         if (dataPtr !== lastPtr) begin
            `CHECK("dataPtr", (ptrQ.size() > 0) ? ptrQ.pop_front() : lastPtr, dataPtr)
            lastPtr = dataPtr;
         end
      end
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic run(input logic [7:0] sub, input string name);
      master.open_frame();
      master.shift(sub, 8);
      foreach (bq[i]) master.shift(bq[i], 8);
      master.close_frame();
      for (int n = 0; cmdQ.size() + ptrQ.size() > 0; n++) begin
         if (n == 200) begin
            bad_count++;
            wrap_up();
         end
         @(posedge clk_sys);
      end
      repeat (40) @(posedge clk_sys);
      $display("test %s done", name);
      bq = {};
   endtask
   function automatic void ram(input logic [7:0] v);
      bq.push_back(v);
      ramModel[ptrExp] = v;
      ptrExp++;
      ptrQ.push_back(ptrExp);
   endfunction
   function automatic void cmd(input logic [7:0] v);
      bq.push_back(v);
      cmdQ.push_back(v);
   endfunction
   initial begin
      reset = 1'b1;
      ptrExp = 7'h00;
      void'($urandom(32'h8842c076));
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2) @(posedge clk_sys);
      bq = {8'h40};
      // a full lap of the pointer, so every ram word holds a known byte
      repeat (128) ram($urandom);
      run(8'h20 | ($urandom & 8'h1F), "ram run");
      bq = {8'h80};
      cmd($urandom);
      bq.push_back(8'hC0);
      ram($urandom);
      bq.push_back(8'h00);
      cmd($urandom);
      cmd($urandom);
      run(8'h20, "mixed");
      for (int i = 0; i < 3; i++) begin
         k = enCount;
         bq = {8'h00, 8'($urandom), 8'($urandom)};
         run({i[0], codes[i], 5'h00}, "foreign code");
         `CHECK("outEn foreign", k, enCount)
      end
      master.open_frame();
      master.shift(8'h20, 8);
      master.shift(8'h00, 8);
      master.shift(8'hA5, 5);
      master.close_frame();
      bq = {8'h00};
      cmd($urandom);
      run(8'h20, "partial byte");
      master.open_frame();
      master.shift(8'hA0, 8);
      master.shift(8'h00, 8);
      @(negedge clk_sys);
      `CHECK("outEn read", 1'b1, serialDataOutEn)
      `CHECK("read byte", ramModel[ptrExp], master.readByte)
      master.close_frame();
      bq = {8'($urandom)};
      run(8'hA0, "read");
      @(negedge clk_sys);
      `CHECK("outEn idle", 1'b0, serialDataOutEn)
      `CHECK("overflow", 1'b0, overflow)
      wrap_up();
   end
endmodule
`default_nettype wire
